// >>> verilog/pnp_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and carriers for the port 4 block
package pnp_pkg;
    // Register byte offsets
    localparam logic [7:0] PNP_OFF_DIR    = 8'h00;
    localparam logic [7:0] PNP_OFF_DATA   = 8'h04;
    localparam logic [7:0] PNP_OFF_PULLUP = 8'h08;
    localparam logic [7:0] PNP_OFF_NCE    = 8'h0C;
    localparam logic [7:0] PNP_OFF_NCMC   = 8'h10;
    localparam logic [7:0] PNP_OFF_NCCS   = 8'h14;
    localparam logic [7:0] PNP_OFF_CTRL   = 8'h18;
    // Reset values
    localparam logic [7:0] PNP_DIR_RST_M1 = 8'h40;
    localparam logic [7:0] PNP_DIR_RST_M23 = 8'h00;
    localparam logic [7:0] PNP_ZERO8      = 8'h00;
    // Field positions
    localparam int         PNP_PULLUP_LO  = 3;
    localparam int         PNP_PULLUP_HI  = 5;
    localparam int         PNP_NCCS_W     = 3;
    localparam int         PNP_CTRL_W     = 5;
    // Operating mode code with the external bus forced on
    localparam logic [1:0] PNP_MODE1      = 2'h1;
    // Prescaler width and shift per sample-cycle code (divide by 2**shift)
    localparam int         PNP_PRESC_W    = 18;
    localparam logic [7:0][4:0] PNP_DIV_SHIFT = {5'h12, 5'h11, 5'h10, 5'h0F,
                                                 5'h0E, 5'h0D, 5'h05, 5'h01};
    localparam logic [1:0] PNP_HTRANS_NSEQ = 2'h2;

    // Pin-function control bits, highest bit first (ext_bus_enable is bit 0)
    typedef struct packed {
        logic strobe_select;
        logic sub_clock_in_en;
        logic i2c_enable;
        logic bus_hold_select;
        logic ext_bus_enable;
    } pnp_ctrl_t;

    // Bus strobes from the bus controller, all active low
    typedef struct packed {
        logic address_strobe_n;
        logic io_select_strobe_n;
        logic write_strobe_n;
        logic read_strobe_n;
    } pnp_strobe_t;
endpackage
`default_nettype wire

// >>> verilog/pnp_port4.sv
// Contract
// - Pull-up on only for input pin with bit
// - Enable bit per pin turns canceller on
// - Filtered level stored only at sample ticks
// - Expected high: stable high stores one
// - Expected low: stable low stores zero
// - Cycle field selects divide 2 to 262144
// - Upper sample-cycle bits undefined, write zero
// - Pin 7 wait, I2C data or port
// - I2C data open-drain, port drives both
// - Pin 6 clock out, subclock or input
// - Pin 5 address or I/O strobe
// - Pin 4 write strobe in expanded mode
// - Pin 3 read strobe in expanded mode
// - Port read: data if output, else pin (the code also reads the data register for noise-cancelled inputs)
// - Direction resets 0x40 mode 1, else 0x00
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pnp_port4 #(
    parameter int PRESC_W = pnp_pkg::PNP_PRESC_W
) (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Chip-level strap and peripheral signals
    input  wire logic [1:0]          op_mode,
    input  wire pnp_pkg::pnp_strobe_t bus_strobe,
    input  wire logic                i2c_drive_low,
    // Pads
    input  wire logic [7:0]          pin_in,
    output logic [7:0]               pin_out,
    output logic [7:0]               pin_oe_n,
    output logic [7:0]               pullup_on,
    output logic                     clk_out_en,
    // Pin levels handed to peripherals
    output logic                     bus_wait_n,
    output logic                     i2c_data_in,
    output logic                     sub_clock_in
);
    import pnp_pkg::*;

    // ==========================================================
    // Parameter check
    // Refused at elaboration: a narrower counter cannot reach the slowest rate
    if (PRESC_W != PNP_PRESC_W) begin : g_presc_chk
        $error("pnp_port4: PRESC_W must equal the widest divider shift");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]         sync1;
        logic [7:0]         sync2;
        logic [7:0]         sync3;
        logic [7:0]         pin_f;
        logic [PRESC_W-1:0] presc;
        logic [7:0]         nc_prev;
        logic [7:0]         direction_reg;
        logic [7:0]         port_data_reg;
        logic [2:0]         pullup_control;
        logic [7:0]         noise_cancel_enable;
        logic [7:0]         noise_expected_level;
        logic [2:0]         noise_sample_cycle;
        pnp_ctrl_t          ctrl;
        logic               init_done;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        rdata;
        logic [7:0]         pin_out;
        logic [7:0]         pin_oe_n;
        logic [7:0]         pullup_on;
        logic               clk_out_en;
        logic               bus_wait_n;
        logic               i2c_data_in;
        logic               sub_clock_in;
    } pnp_state_t;

    pnp_state_t st_r;
    pnp_state_t st_nxt;

    logic               ext_bus;
    logic               tick;
    logic [PRESC_W-1:0] tick_mask;
    logic [7:0]         stable_m;
    logic [7:0]         nc_upd;
    logic [7:0]         port_view;
    logic               bus_acc;

    // ==========================================================
    // Shared helpers
    // Mode 1 always runs the external bus; modes 2 and 3 take it from software
    assign ext_bus   = (op_mode == PNP_MODE1) | st_r.ctrl.ext_bus_enable;
    // One prescaler for all pins; the mask follows the field at once, so a
    // rewrite may give one short or long first interval
    assign tick_mask = ~({PRESC_W{1'b1}} << PNP_DIV_SHIFT[st_r.noise_sample_cycle]);
    assign tick      = (st_r.presc & tick_mask) == tick_mask;
    // Stable means this tick's level equals the previous tick's
    assign stable_m  = ~(st_r.pin_f ^ st_r.nc_prev);
    // The stored bit is the stable level itself: equal to the expected
    // level when that is seen, the other value otherwise
    assign nc_upd    = tick ? (st_r.noise_cancel_enable & stable_m) : PNP_ZERO8;
    // Filtered pins read from the data register, like outputs
    assign port_view = ((st_r.direction_reg | st_r.noise_cancel_enable) & st_r.port_data_reg)
                     | (~(st_r.direction_reg | st_r.noise_cancel_enable) & st_r.pin_f);
    // Only NONSEQ starts a transfer; IDLE and BUSY slots are ignored
    assign bus_acc   = hsel & hready & (htrans == PNP_HTRANS_NSEQ);

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Three-stage synchroniser; a change counts when stages 2 and 3 agree
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.pin_f = (st_r.sync2 & st_r.sync3) | (st_r.pin_f & (st_r.sync2 | st_r.sync3));
        st_nxt.presc = st_r.presc + 1'b1;
        // Noise canceller sampling
        if (tick) begin
            st_nxt.nc_prev = st_r.pin_f;
        end
        st_nxt.port_data_reg = (st_r.port_data_reg & ~nc_upd) | (st_r.pin_f & nc_upd);
        // Strap caught on the first edge after reset release
        if (!st_r.init_done) begin
            st_nxt.init_done     = 1'b1;
            st_nxt.direction_reg = (op_mode == PNP_MODE1) ? PNP_DIR_RST_M1 : PNP_DIR_RST_M23;
        end
        // Data phase of a write; the canceller wins a bit it updates now
        if (st_r.wr_pend) begin
            if (st_r.wr_addr == PNP_OFF_DIR) begin
                st_nxt.direction_reg = hwdata[7:0];
            end else if (st_r.wr_addr == PNP_OFF_DATA) begin
                st_nxt.port_data_reg = (hwdata[7:0] & ~nc_upd) | (st_r.pin_f & nc_upd);
            end else if (st_r.wr_addr == PNP_OFF_PULLUP) begin
                st_nxt.pullup_control = hwdata[PNP_PULLUP_HI:PNP_PULLUP_LO];
            end else if (st_r.wr_addr == PNP_OFF_NCE) begin
                st_nxt.noise_cancel_enable = hwdata[7:0];
            end else if (st_r.wr_addr == PNP_OFF_NCMC) begin
                st_nxt.noise_expected_level = hwdata[7:0];
            end else if (st_r.wr_addr == PNP_OFF_NCCS) begin
                st_nxt.noise_sample_cycle = hwdata[PNP_NCCS_W-1:0];
            end else if (st_r.wr_addr == PNP_OFF_CTRL) begin
                st_nxt.ctrl = pnp_ctrl_t'(hwdata[PNP_CTRL_W-1:0]);
            end
        end
        // Address phase; read data is fetched now so it leaves a flop
        st_nxt.wr_pend = bus_acc & hwrite;
        if (bus_acc) begin
            st_nxt.wr_addr = haddr[7:0];
            if (!hwrite) begin
                st_nxt.rdata = 32'h0000_0000;
                if (haddr[7:0] == PNP_OFF_DIR) begin
                    st_nxt.rdata[7:0] = st_r.direction_reg;
                end else if (haddr[7:0] == PNP_OFF_DATA) begin
                    st_nxt.rdata[7:0] = port_view;
                end else if (haddr[7:0] == PNP_OFF_PULLUP) begin
                    st_nxt.rdata[PNP_PULLUP_HI:PNP_PULLUP_LO] = st_r.pullup_control;
                end else if (haddr[7:0] == PNP_OFF_NCE) begin
                    st_nxt.rdata[7:0] = st_r.noise_cancel_enable;
                end else if (haddr[7:0] == PNP_OFF_NCMC) begin
                    st_nxt.rdata[7:0] = st_r.noise_expected_level;
                end else if (haddr[7:0] == PNP_OFF_NCCS) begin
                    st_nxt.rdata[PNP_NCCS_W-1:0] = st_r.noise_sample_cycle;
                end else if (haddr[7:0] == PNP_OFF_CTRL) begin
                    st_nxt.rdata[PNP_CTRL_W-1:0] = st_r.ctrl;
                end
            end
        end
        // Pull-ups only where the pin is a plain input
        st_nxt.pullup_on = PNP_ZERO8;
        st_nxt.pullup_on[PNP_PULLUP_HI:PNP_PULLUP_LO] = st_r.pullup_control
            & ~st_r.direction_reg[PNP_PULLUP_HI:PNP_PULLUP_LO] & {3{~ext_bus}};
        // Default pin functions: plain port per direction bit
        st_nxt.pin_out  = st_r.port_data_reg;
        st_nxt.pin_oe_n = ~st_r.direction_reg;
        st_nxt.bus_wait_n   = 1'b1;
        st_nxt.i2c_data_in  = 1'b1;
        // Pin 7: wait input, I2C data or port
        if (ext_bus && st_r.ctrl.bus_hold_select) begin
            st_nxt.pin_oe_n[7] = 1'b1;
            st_nxt.bus_wait_n  = st_r.pin_f[7];
        end else if (st_r.ctrl.i2c_enable) begin
            // Open-drain: drive only a low, release otherwise
            st_nxt.pin_out[7]  = 1'b0;
            st_nxt.pin_oe_n[7] = ~i2c_drive_low;
            st_nxt.i2c_data_in = st_r.pin_f[7];
        end
        // Pin 6: clock out selected here, the pad mux uses clk_out_en
        st_nxt.clk_out_en   = st_r.direction_reg[6];
        st_nxt.pin_out[6]   = 1'b0;
        st_nxt.sub_clock_in = ~st_r.direction_reg[6] & st_r.ctrl.sub_clock_in_en
                            & st_r.pin_f[6];
        // Pins 5 to 3 carry the bus strobes while the bus is on
        if (ext_bus) begin
            st_nxt.pin_out[5] = st_r.ctrl.strobe_select ? bus_strobe.io_select_strobe_n
                                                        : bus_strobe.address_strobe_n;
            st_nxt.pin_out[4] = bus_strobe.write_strobe_n;
            st_nxt.pin_out[3] = bus_strobe.read_strobe_n;
            st_nxt.pin_oe_n[5:3] = 3'h0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r          <= '0;
            st_r.pin_oe_n <= 8'hFF;
            st_r.bus_wait_n  <= 1'b1;
            st_r.i2c_data_in <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops; zero-wait slave, always OKAY
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = st_r.rdata;
    assign pin_out      = st_r.pin_out;
    assign pin_oe_n     = st_r.pin_oe_n;
    assign pullup_on    = st_r.pullup_on;
    assign clk_out_en   = st_r.clk_out_en;
    assign bus_wait_n   = st_r.bus_wait_n;
    assign i2c_data_in  = st_r.i2c_data_in;
    assign sub_clock_in = st_r.sub_clock_in;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [2:0] pull_exp;
    logic       i2c_mode;
    logic       dr_wr;
    assign pull_exp = st_r.pullup_control & ~st_r.direction_reg[5:3] & {3{~ext_bus}};
    assign i2c_mode = !(ext_bus && st_r.ctrl.bus_hold_select) && st_r.ctrl.i2c_enable;
    assign dr_wr    = st_r.wr_pend && (st_r.wr_addr == PNP_OFF_DATA);

    pullup_gate_a: assert property (##1 pullup_on[5:3] == $past(pull_exp))
        else $error("pull-up state does not follow control and direction");
    nc_bypass_a: assert property (!dr_wr |=>
        ((st_r.port_data_reg ^ $past(st_r.port_data_reg)) & ~$past(st_r.noise_cancel_enable))
        == 8'h00)
        else $error("disabled canceller changed the data register");
    nc_tick_only_a: assert property (!dr_wr && !tick |=> $stable(st_r.port_data_reg))
        else $error("data register changed between sample ticks");
    nc_level_a: assert property (tick && !dr_wr |=>
        ((st_r.port_data_reg ^ $past(st_r.pin_f))
        & $past(st_r.noise_cancel_enable & stable_m)) == 8'h00)
        else $error("stable level not stored into the data register");
    div_two_a: assert property (tick && st_r.noise_sample_cycle == 3'h0 && !st_r.wr_pend
        |=> !tick)
        else $error("divide-by-two tick came on consecutive cycles");
    // A rewrite to code 0 inside the window legally speeds the tick up at once
    div_32_a: assert property (tick && st_r.noise_sample_cycle == 3'h1 && !st_r.wr_pend
        |=> (!tick || st_r.noise_sample_cycle == 3'h0) [*8])
        else $error("divide-by-32 tick came too early");
    nccs_upper_a: assert property (bus_acc && !hwrite && haddr[7:0] == PNP_OFF_NCCS
        |=> hrdata[31:3] == 29'h0)
        else $error("upper sample-cycle bits not zero on read");
    pin7_i2c_a: assert property (i2c_mode |=>
        pin_out[7] == 1'b0 && pin_oe_n[7] == !$past(i2c_drive_low))
        else $error("pin 7 not open-drain in I2C mode");
    pin6_clk_a: assert property (st_r.direction_reg[6] |=> clk_out_en && !sub_clock_in)
        else $error("pin 6 clock output not selected");
    pin5_strobe_a: assert property (ext_bus |=> !pin_oe_n[5] && pin_out[5] ==
        ($past(st_r.ctrl.strobe_select) ? $past(bus_strobe.io_select_strobe_n)
                                        : $past(bus_strobe.address_strobe_n)))
        else $error("pin 5 strobe wrong");
    pin43_strobe_a: assert property (ext_bus |=> pin_oe_n[4:3] == 2'h0 && pin_out[4:3] ==
        $past({bus_strobe.write_strobe_n, bus_strobe.read_strobe_n}))
        else $error("pin 4 or 3 strobe wrong");
    port_read_a: assert property (bus_acc && !hwrite && haddr[7:0] == PNP_OFF_DATA
        |=> hrdata[7:0] == $past(port_view))
        else $error("port read value wrong");
    dir_init_a: assert property ($rose(st_r.init_done) |-> st_r.direction_reg ==
        (op_mode == PNP_MODE1 ? PNP_DIR_RST_M1 : PNP_DIR_RST_M23))
        else $error("direction reset value wrong");

    nc_update_c: cover property (tick && (nc_upd & (st_r.port_data_reg ^ st_r.pin_f)) != 8'h00);
    i2c_mode_c:  cover property (i2c_mode && i2c_drive_low);
    ext_bus_c:   cover property (ext_bus && st_r.ctrl.strobe_select);
    wait_c:      cover property (!bus_wait_n);
endmodule
`default_nettype wire

// >>> tb/pnp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Board side of the port: far-end drivers, pull-ups, wire level
module pnp_pin_model (
    // Clock
    input  wire logic       hclk,
    // Pad controls from the port
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pullup_on,
    input  wire logic       clk_out_en,
    // Far-end drivers set by the bench
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // Resolved pad level
    output logic [7:0]      pin_lvl
);
    logic flt_r = 1'b0;

    // A floating pad toggles each clock; stages 2 and 3 never agree, so a missing pull-up reads as the last filtered level
    always @(posedge hclk) begin
        flt_r <= ~flt_r;
    end

    // Port drive wins, then the far end, then the pull-up, else the pad floats
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_lvl[i] = (i == 6 && clk_out_en) ? hclk : pin_out[i];
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = flt_r;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/pnp_port4_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the port 4 block
module pnp_port4_tb;
    import pnp_pkg::*;
    localparam int LIMIT = 60000;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hready, hreadyout, hresp, i2c_drive_low;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, op_mode;
    logic [2:0]  hsize;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pullup_on, ext_val, ext_en, d, p, v, e;
    logic        clk_out_en, bus_wait_n, i2c_data_in, sub_clock_in;
    pnp_strobe_t bus_strobe;
    logic [15:0] lfsr_r = 16'h0049;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    // 125 MHz clock; single slave, so its ready is the bus ready
    always #4 hclk = ~hclk;
    assign hready = hreadyout;

    pnp_port4 uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_mode(op_mode),
        .bus_strobe(bus_strobe), .i2c_drive_low(i2c_drive_low), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
        .clk_out_en(clk_out_en), .bus_wait_n(bus_wait_n), .i2c_data_in(i2c_data_in),
        .sub_clock_in(sub_clock_in));
    pnp_pin_model board (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .clk_out_en(clk_out_en), .ext_val(ext_val),
        .ext_en(ext_en), .pin_lvl(pin_in));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Port read view: data bit where output, pad level where input
    function automatic logic [7:0] port_view(input logic [7:0] dir, dat, pins);
        return (dat & dir) | (pins & ~dir);
    endfunction

    task automatic rnd(output logic [7:0] x);
        lfsr_r = lfsr_next(lfsr_r);
        x = lfsr_r[7:0];
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer, plus an idle slot against the read-after-write hazard
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= PNP_HTRANS_NSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic reset_dut(input logic [1:0] mode);
        hresetn <= 1'b0;
        op_mode <= mode;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask

    // Level change must need two ticks of the chosen rate before it is stored
    task automatic nc_case(input logic [2:0] code, input int div, input logic [7:0] mask);
        logic [7:0] v0, lv;
        rnd(v0);
        rnd(lv);
        xfer(1'b1, PNP_OFF_NCCS, {29'h0, code}, r);
        xfer(1'b1, PNP_OFF_NCE, {24'h0, mask}, r);
        xfer(1'b1, PNP_OFF_NCMC, {24'h0, lv}, r);
        ext_val <= v0;
        tick(2 * div + 8);
        xfer(1'b0, PNP_OFF_DATA, 32'h0, r);
        chk(r, {24'h0, v0});
        ext_val <= ~v0;
        if (div > 2) begin
            tick(div / 2);
            xfer(1'b0, PNP_OFF_DATA, 32'h0, r);
            chk(r, {24'h0, (v0 & mask) | (~v0 & ~mask)});
        end
        tick(2 * div + 8);
        xfer(1'b0, PNP_OFF_DATA, 32'h0, r);
        chk(r, {24'h0, ~v0});
        $display("noise code %0d done", code);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            final_report();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        op_mode = 2'h2;
        bus_strobe = pnp_strobe_t'(4'hF);
        i2c_drive_low = 1'b0;
        ext_val = 8'h00;
        ext_en = 8'hFF;
        reset_dut(2'h2);
        // Reset values, with the unmapped slot after the last register
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, 8'(4 * k), 32'h0, r);
            chk(r, 32'h0);
        end
        $display("reset values done");
        // Random direction, pull-up and data against random far-end levels
        repeat (12) begin
            rnd(d);
            rnd(p);
            rnd(v);
            rnd(e);
            ext_en <= ~d;
            ext_val <= v;
            xfer(1'b1, PNP_OFF_DIR, {24'h0, d}, r);
            xfer(1'b1, PNP_OFF_PULLUP, {24'h0, p & 8'h38}, r);
            xfer(1'b1, PNP_OFF_DATA, {24'h0, e}, r);
            tick(4);
            chk(pullup_on, {24'h0, p & 8'h38 & ~d});
            chk(pin_oe_n, {24'h0, ~d});
            chk({pin_out, 7'h0, clk_out_en}, {e & 8'hBF, 7'h0, d[6]});
            xfer(1'b0, PNP_OFF_DATA, 32'h0, r);
            chk(r, {24'h0, port_view(d, e, v)});
        end
        $display("direction and pull-up done");
        // Bus strobes own pins 5 to 3 whatever the direction bits say
        for (int s = 0; s < 2; s++) begin
            xfer(1'b1, PNP_OFF_CTRL, 32'h1 | (s << 4), r);
            repeat (6) begin
                rnd(v);
                bus_strobe <= pnp_strobe_t'(v[3:0]);
                tick(3);
                chk({pin_out[5:3], pin_oe_n[5:3]}, {s ? v[2] : v[3], v[1:0], 3'h0});
            end
        end
        $display("strobes done");
        // Wait input, I2C data and subclock input follow the far end
        ext_en <= 8'hFF;
        xfer(1'b1, PNP_OFF_DIR, 32'h0, r);
        for (int b = 0; b < 2; b++) begin
            ext_val <= {b[0], b[0], 6'h0};
            xfer(1'b1, PNP_OFF_CTRL, 32'h0B, r);
            tick(6);
            chk({bus_wait_n, pin_oe_n[7], sub_clock_in}, {b[0], 1'b1, b[0]});
            xfer(1'b1, PNP_OFF_CTRL, 32'h04, r);
            i2c_drive_low <= 1'b1;
            tick(3);
            chk({pin_oe_n[7], pin_out[7]}, 2'h0);
            i2c_drive_low <= 1'b0;
            // Release, three sync stages, agreement and the output flop
            tick(8);
            chk({i2c_data_in, pin_oe_n[7]}, {b[0], 1'b1});
        end
        $display("alternate functions done");
        // Noise canceller at the three shortest sampling rates
        xfer(1'b1, PNP_OFF_CTRL, 32'h0, r);
        nc_case(3'h0, 2, 8'hFF);
        nc_case(3'h1, 32, 8'h0F);
        nc_case(3'h2, 8192, 8'hA5);
        // Mode 1 strap: clock on pin 6, strobes forced on pins 4 and 3
        bus_strobe <= pnp_strobe_t'(4'hA);
        reset_dut(2'h1);
        xfer(1'b0, PNP_OFF_DIR, 32'h0, r);
        chk(r, {24'h0, PNP_DIR_RST_M1});
        chk({clk_out_en, pin_out[4:3], pin_oe_n[4:3]}, 5'b11000);
        $display("mode 1 done");
        final_report();
    end
endmodule
`default_nettype wire
